// ==== logic/cie_exec_core.sv ====
// module: instruction execute subset with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module cie_exec_core
	import cie_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic      [1:0]        bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic      [31:0]       rdata,
	output logic      [1:0]        rresp,
	output logic                   rvalid,
	input  wire logic              rready
);

	cie_state_t         state;
	cie_instr_t         cur;
	logic [7:0]         acc, status, wdt_count, wdt_presc, mem_wdata, mem_rdata, result;
	logic [PC_W-1:0]    pc, stack1, stack2;
	logic [31:0]        cycles, rd_mux;
	logic [11:0]        last_instr;
	logic [FADDR_W-1:0] mem_addr;
	logic               wdt_psa, skip_pend, rd_pend, mem_we, res_zero, rd_ok;
	logic               exec, exec_jump, file_op, wr_go, rd_go, wr_instr, wr_file;

	function automatic logic is_file(input logic [ADDR_W-1:0] a);
		return (a[7] == OFF_FILE[7]) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				m[i*8 +: 8] = nw[i*8 +: 8];
		return m;
	endfunction

	function automatic logic sw_hit(input logic go, input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		return go && (a == off);
	endfunction

	cie_file_mem
	#(
		.DEPTH  (FILE_REGS),
		.WIDTH  (8),
		.ADDR_W (FADDR_W)
	)
	u_mem
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.we      (mem_we),
		.addr    (mem_addr),
		.wdata   (mem_wdata),
		.rdata   (mem_rdata)
	);

	assign wr_go     = awready && awvalid && wvalid;
	assign rd_go     = arready && arvalid;
	assign wr_instr  = sw_hit(wr_go, awaddr, OFF_INSTR);
	assign wr_file   = wr_go && is_file(awaddr);
	assign exec      = (state == ST_EXEC);
	assign exec_jump = exec && (cur.op == OP_SUB_JUMP);
	assign file_op   = (cur.op == OP_INVERT) || (cur.op == OP_DEC) || (cur.op == OP_DEC_SKIP);
	assign res_zero  = (result == 8'h00);

	always_comb
	begin
		case (cur.op)
			OP_INVERT:   result = ~mem_rdata;
			OP_DEC:      result = 8'(mem_rdata - 8'h01);
			OP_DEC_SKIP: result = 8'(mem_rdata - 8'h01);
			default:     result = 8'h00;
		endcase
	end

	// one memory port: core owns it while executing, the bus only when idle
	always_comb
	begin
		mem_we    = 1'b0;
		mem_addr  = cur.faddr;
		mem_wdata = result;
		if (exec)
			mem_we = (cur.op == OP_ZERO_FILE) || (file_op && cur.dest);
		else if (wr_instr)
			mem_addr = wdata[FADDR_W-1:0];
		else if (wr_file)
		begin
			mem_we    = wstrb[0];
			mem_addr  = awaddr[FADDR_W+1:2];
			mem_wdata = wdata[7:0];
		end
		else if (rd_go)
			mem_addr = araddr[FADDR_W+1:2];
	end

	// fetch, execute and the second cycle of a subroutine jump
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state      <= ST_IDLE;
			cur        <= '0;
			skip_pend  <= 1'b0;
			last_instr <= 12'h000;
		end
		else
		begin
			case (state)
				ST_IDLE:
					if (wr_instr)
					begin
						state      <= ST_EXEC;
						last_instr <= wdata[11:0];
						skip_pend  <= 1'b0;
						// a pending skip turns the fetched word into a no-op
						cur <= skip_pend ? cie_instr_t'('0) : cie_decode(wdata[11:0]);
					end
				ST_EXEC:
				begin
					state <= (cur.op == OP_SUB_JUMP) ? ST_JUMP2 : ST_IDLE;
					if (cur.op == OP_DEC_SKIP && res_zero)
						skip_pend <= 1'b1;
				end
				ST_JUMP2:
					state <= ST_IDLE;
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cycles <= 32'h0000_0000;
		else if (exec || state == ST_JUMP2)
			cycles <= cycles + 32'h0000_0001;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			acc <= ACC_RESET;
		else if (exec && cur.op == OP_ACC_CLEAR)
			acc <= 8'h00;
		else if (exec && file_op && !cur.dest)
			acc <= result;
		else if (sw_hit(wr_go, awaddr, OFF_ACC))
			acc <= 8'(merge({24'h0, acc}, wdata, wstrb));
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			status <= STATUS_RESET;
		else if (exec)
		begin
			case (cur.op)
				OP_ZERO_FILE, OP_ACC_CLEAR:
					status[ST_ZERO_BIT] <= 1'b1;
				OP_INVERT, OP_DEC:
					status[ST_ZERO_BIT] <= res_zero;
				OP_WDT_KICK:
				begin
					status[ST_EXPIRY_BIT] <= 1'b1;
					status[ST_SLEEP_BIT]  <= 1'b1;
				end
				default:
					status <= status;
			endcase
		end
		else if (sw_hit(wr_go, awaddr, OFF_STATUS))
			status <= 8'(merge({24'h0, status}, wdata, wstrb));
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pc     <= PC_RESET;
			stack1 <= '0;
			stack2 <= '0;
		end
		else if (exec_jump)
		begin
			stack2 <= stack1;
			stack1 <= PC_W'(pc + 11'h001);
			pc     <= {status[ST_PAGE_HI:ST_PAGE_LO], 1'b0, cur.lit};
		end
		else if (exec)
			pc <= PC_W'(pc + 11'h001);
		else if (sw_hit(wr_go, awaddr, OFF_PC))
			pc <= PC_W'(merge({21'h0, pc}, wdata, wstrb));
	end

	// prescaler, when assigned, divides the watchdog count by 256
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wdt_count <= 8'h00;
			wdt_presc <= 8'h00;
			wdt_psa   <= PSA_RESET;
		end
		else
		begin
			if (sw_hit(wr_go, awaddr, OFF_WDT) && wstrb[2])
				wdt_psa <= wdata[WDT_PSA_BIT];
			if (exec && cur.op == OP_WDT_KICK)
				wdt_count <= 8'h00;
			else if (!wdt_psa || wdt_presc == 8'hFF)
				wdt_count <= 8'(wdt_count + 8'h01);
			// the timer side keeps its prescaler running through a kick
			if (exec && cur.op == OP_WDT_KICK && wdt_psa)
				wdt_presc <= 8'h00;
			else
				wdt_presc <= 8'(wdt_presc + 8'h01);
		end
	end

	// write channel: address and data are taken together, one write at a time
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
		end
		else
		begin
			awready <= awvalid && wvalid && !awready && !bvalid && state == ST_IDLE && !arready;
			wready  <= awvalid && wvalid && !awready && !bvalid && state == ST_IDLE && !arready;
			if (wr_go)
			begin
				bvalid <= 1'b1;
				bresp  <= (awaddr[1:0] == 2'h0 && (awaddr <= OFF_CYCLES || is_file(awaddr))) ?
					RESP_OKAY : RESP_SLVERR;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end

	always_comb
	begin
		rd_ok  = 1'b1;
		rd_mux = 32'h0000_0000;
		case (araddr)
			OFF_INSTR:  rd_mux = {20'h0, last_instr};
			OFF_ACC:    rd_mux = {24'h0, acc};
			OFF_STATUS: rd_mux = {24'h0, status};
			OFF_PC:     rd_mux = {21'h0, pc};
			OFF_STACK1: rd_mux = {21'h0, stack1};
			OFF_STACK2: rd_mux = {21'h0, stack2};
			OFF_WDT:    rd_mux = {15'h0, wdt_psa, wdt_presc, wdt_count};
			OFF_CYCLES: rd_mux = cycles;
			default:    rd_ok  = is_file(araddr);
		endcase
	end

	// file reads wait one cycle for the registered memory output
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rd_pend <= 1'b0;
			rvalid  <= 1'b0;
			rresp   <= RESP_OKAY;
			rdata   <= 32'h0000_0000;
		end
		else
		begin
			arready <= arvalid && !arready && !rvalid && !rd_pend && state == ST_IDLE &&
				!awready && !(awvalid && wvalid);
			rd_pend <= rd_go && is_file(araddr);
			if (rd_go && !is_file(araddr))
			begin
				rvalid <= 1'b1;
				rdata  <= rd_mux;
				rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rd_pend)
			begin
				rvalid <= 1'b1;
				rdata  <= {24'h0, mem_rdata};
				rresp  <= RESP_OKAY;
			end
			else if (rready)
				rvalid <= 1'b0;
		end
	end

	a_jump_low_pc: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_jump |=> pc[7:0] == $past(cur.lit))
		else $error("jump did not load the literal into the low counter bits");
	a_jump_page_bits: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_jump |=> pc[10:9] == $past(status[6:5]) && !pc[8] && status == $past(status))
		else $error("jump page bits or status wrong");
	a_jump_push_len: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_jump |=> stack1 == PC_W'($past(pc) + 11'h001) && state == ST_JUMP2 ##1
		state == ST_IDLE)
		else $error("jump push or two-cycle length wrong");
	a_stack_shift: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_jump |=> stack2 == $past(stack1))
		else $error("stack level two not loaded from level one");
	a_zero_file: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && cur.op == OP_ZERO_FILE |-> mem_we && mem_wdata == 8'h00 && mem_addr == cur.faddr
		##1 status[2] && state == ST_IDLE)
		else $error("file zeroing did not clear register or set zero flag");
	a_acc_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && cur.op == OP_ACC_CLEAR |=> acc == 8'h00 && status[2] && state == ST_IDLE)
		else $error("accumulator clear wrong");
	a_wdt_kick: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && cur.op == OP_WDT_KICK |=> wdt_count == 8'h00 &&
		wdt_presc == ($past(wdt_psa) ? 8'h00 : 8'($past(wdt_presc) + 8'h01)))
		else $error("watchdog kick did not clear counter or prescaler correctly");
	a_kick_flags: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && cur.op == OP_WDT_KICK |=> status[4] && status[3])
		else $error("watchdog kick flags not set");
	a_invert_route: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && cur.op == OP_INVERT && !cur.dest |-> !mem_we ##1 acc == ~$past(mem_rdata) &&
		status[2] == ($past(mem_rdata) == 8'hFF))
		else $error("invert to accumulator wrong");
	a_dec_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && cur.op == OP_DEC |=> status[2] == ($past(mem_rdata) == 8'h01))
		else $error("decrement zero flag wrong");
	a_skip_flags: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && cur.op == OP_DEC_SKIP |=> status == $past(status) &&
		skip_pend == ($past(mem_rdata) == 8'h01))
		else $error("decrement skip touched status or skip state wrong");
	a_skip_discard: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_instr && skip_pend |=> cur.op == OP_NOP && !skip_pend)
		else $error("fetched instruction not discarded after skip");

endmodule
`default_nettype wire

// ==== logic/cie_file_mem.sv ====
// module: file register storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module cie_file_mem
#(
	parameter int unsigned DEPTH  = 32,
	parameter int unsigned WIDTH  = 8,
	parameter int unsigned ADDR_W = 5
)
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [WIDTH-1:0]  wdata,
	output logic      [WIDTH-1:0]  rdata
);

	logic [WIDTH-1:0] mem [DEPTH];

	// contents are not reset: software preloads what a test needs
	always_ff @(posedge aclk)
	begin
		if (we)
			mem[addr] <= wdata;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rdata <= '0;
		else
			rdata <= mem[addr];
	end

endmodule
`default_nettype wire

// ==== logic/cie_pkg.sv ====
// package: offsets, field positions, encodings and types of the instruction execute block
`default_nettype none
package cie_pkg;

	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned PC_W       = 11;
	localparam int unsigned FADDR_W    = 5;
	localparam int unsigned FILE_REGS  = 32;

	localparam logic [7:0] OFF_INSTR   = 8'h00;
	localparam logic [7:0] OFF_ACC     = 8'h04;
	localparam logic [7:0] OFF_STATUS  = 8'h08;
	localparam logic [7:0] OFF_PC      = 8'h0C;
	localparam logic [7:0] OFF_STACK1  = 8'h10;
	localparam logic [7:0] OFF_STACK2  = 8'h14;
	localparam logic [7:0] OFF_WDT     = 8'h18;
	localparam logic [7:0] OFF_CYCLES  = 8'h1C;
	localparam logic [7:0] OFF_FILE    = 8'h80;

	localparam int unsigned ST_ZERO_BIT     = 2;
	localparam int unsigned ST_SLEEP_BIT    = 3;
	localparam int unsigned ST_EXPIRY_BIT   = 4;
	localparam int unsigned ST_PAGE_LO      = 5;
	localparam int unsigned ST_PAGE_HI      = 6;
	localparam int unsigned WDT_PSA_BIT     = 16;

	localparam logic [PC_W-1:0] PC_RESET     = 11'h7FF;
	localparam logic [7:0]      STATUS_RESET = 8'h18;
	localparam logic [7:0]      ACC_RESET    = 8'h00;
	localparam logic            PSA_RESET    = 1'b1;

	localparam logic [3:0]  ENC_JUMP_HI      = 4'h9;
	localparam logic [6:0]  ENC_ZERO_FILE_HI = 7'h03;
	localparam logic [11:0] ENC_ACC_CLEAR    = 12'h040;
	localparam logic [11:0] ENC_WDT_KICK     = 12'h004;
	localparam logic [5:0]  ENC_INVERT_HI    = 6'h09;
	localparam logic [5:0]  ENC_DEC_HI       = 6'h03;
	localparam logic [5:0]  ENC_DEC_SKIP_HI  = 6'h0B;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b001,
		ST_EXEC  = 3'b010,
		ST_JUMP2 = 3'b100
	} cie_state_t;

	typedef enum logic [3:0]
	{
		OP_NOP       = 4'h0,
		OP_SUB_JUMP  = 4'h1,
		OP_ZERO_FILE = 4'h2,
		OP_ACC_CLEAR = 4'h3,
		OP_WDT_KICK  = 4'h4,
		OP_INVERT    = 4'h5,
		OP_DEC       = 4'h6,
		OP_DEC_SKIP  = 4'h7
	} cie_op_t;

	typedef struct packed
	{
		cie_op_t              op;
		logic                 dest;
		logic [FADDR_W-1:0]   faddr;
		logic [7:0]           lit;
	} cie_instr_t;

	function automatic cie_instr_t cie_decode(input logic [11:0] code);
		cie_instr_t d;
		d.dest  = code[5];
		d.faddr = code[4:0];
		d.lit   = code[7:0];
		if (code[11:8] == ENC_JUMP_HI)
			d.op = OP_SUB_JUMP;
		else if (code[11:5] == ENC_ZERO_FILE_HI)
			d.op = OP_ZERO_FILE;
		else if (code == ENC_ACC_CLEAR)
			d.op = OP_ACC_CLEAR;
		else if (code == ENC_WDT_KICK)
			d.op = OP_WDT_KICK;
		else if (code[11:6] == ENC_INVERT_HI)
			d.op = OP_INVERT;
		else if (code[11:6] == ENC_DEC_HI)
			d.op = OP_DEC;
		else if (code[11:6] == ENC_DEC_SKIP_HI)
			d.op = OP_DEC_SKIP;
		else
			d.op = OP_NOP;
		return d;
	endfunction

endpackage
`default_nettype wire

// ==== tb/cie_exec_core_tb.sv ====
// self-checking testbench of the instruction execute core
`timescale 1ns/1ps
`default_nettype none
module cie_exec_core_tb
	import cie_pkg::*;
;
	logic              aclk = 1'b0;
	logic              aresetn;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [2:0]        awprot, arprot;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	logic [31:0]       wdata, rdata, d, c0, c1;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp, r;
	logic [51:0]       t;
	int                fails, num_checks;
	// instr, file value, status before, then expected acc, file, status
	localparam logic [51:0] TAB [6] = '{52'h247_13_00_EC_13_00, 52'h267_FF_00_77_00_04,
		52'h0E7_01_00_77_00_04, 52'h0C7_00_04_FF_00_00, 52'h2C7_05_04_04_05_04,
		52'h2E7_01_00_77_00_00};

	always #4 aclk = ~aclk;

	cie_exec_core dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));

	cie_fetch_model fm (.aclk(aclk), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready));

	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %0t %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string m);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %0t %s resp %h expected %h", $time, m, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
		logic [31:0] v;
		logic [1:0]  s;
		fm.rd(a, v, s);
		chk_data(v, e, m);
	endtask

	task automatic w(input logic [7:0] a, input logic [31:0] v);
		logic [1:0] s;
		fm.wr(a, v, s);
		chk_resp(s, RESP_OKAY, "write resp");
	endtask

	function automatic logic [7:0] fa(input int f);
		return OFF_FILE + 8'(4 * f);
	endfunction

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		#400000;
		fails++;
		complete_run();
	end

	initial
	begin
		aresetn = 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(OFF_STATUS, 32'h18, "status reset");
		rd_chk(OFF_PC, 32'h7FF, "pc reset");
		$display("test reset done");
		// pc bit 8 set beforehand so the forced clear shows
		w(OFF_STATUS, 32'h40);
		w(OFF_PC, 32'h123);
		fm.rd(OFF_CYCLES, c0, r);
		w(OFF_INSTR, 32'h9A5);
		fm.rd(OFF_CYCLES, c1, r);
		chk_data(c1 - c0, 32'h2, "call cycles");
		rd_chk(OFF_PC, 32'h4A5, "call pc");
		rd_chk(OFF_STATUS, 32'h40, "call status");
		rd_chk(OFF_STACK1, 32'h124, "call push");
		w(OFF_INSTR, 32'h933);
		w(OFF_INSTR, 32'h911);
		rd_chk(OFF_STACK1, 32'h434, "stack level one");
		rd_chk(OFF_STACK2, 32'h4A6, "stack level two");
		$display("test call done");
		w(fa(5), 32'h5A);
		w(OFF_STATUS, 32'h0);
		w(OFF_INSTR, 32'h065);
		rd_chk(fa(5), 32'h0, "file zeroed");
		rd_chk(OFF_STATUS, 32'h04, "zero flag");
		w(OFF_ACC, 32'h5A);
		w(OFF_STATUS, 32'h0);
		w(OFF_INSTR, 32'h040);
		rd_chk(OFF_ACC, 32'h0, "acc zeroed");
		rd_chk(OFF_STATUS, 32'h04, "zero flag");
		$display("test clear done");
		// counters keep running, so only small values are demanded after the kick
		for (int i = 0; i < 2; i++)
		begin
			w(OFF_STATUS, 32'h0);
			w(OFF_WDT, (i == 0) ? 32'h10000 : 32'h0);
			w(OFF_INSTR, 32'h004);
			fm.rd(OFF_WDT, d, r);
			chk_data({31'h0, d[7:0] < 8'h08}, 32'h1, "wdt counter");
			if (i == 0)
				chk_data({31'h0, d[15:8] < 8'h08}, 32'h1, "prescaler");
			rd_chk(OFF_STATUS, 32'h18, "kick flags");
		end
		$display("test watchdog done");
		for (int i = 0; i < 6; i++)
		begin
			t = TAB[i];
			w(OFF_ACC, 32'h77);
			w(fa(7), {24'h0, t[39:32]});
			w(OFF_STATUS, {24'h0, t[31:24]});
			w(OFF_INSTR, {20'h0, t[51:40]});
			rd_chk(OFF_ACC, {24'h0, t[23:16]}, "acc result");
			rd_chk(fa(7), {24'h0, t[15:8]}, "file result");
			rd_chk(OFF_STATUS, {24'h0, t[7:0]}, "status");
		end
		fm.rd(OFF_PC, d, r);
		w(OFF_INSTR, 32'h040);
		rd_chk(OFF_ACC, 32'h77, "skipped word");
		rd_chk(OFF_PC, (d + 32'h1) & 32'h7FF, "skip pc");
		w(OFF_INSTR, 32'h040);
		rd_chk(OFF_ACC, 32'h0, "after skip");
		$display("test file ops done");
		fm.rd(8'h40, d, r);
		chk_resp(r, RESP_SLVERR, "unmapped read");
		chk_data(d, 32'h0, "unmapped data");
		fm.wr(8'h40, 32'h1, r);
		chk_resp(r, RESP_SLVERR, "unmapped write");
		fm.wr(OFF_STACK1, 32'h3, r);
		chk_resp(r, RESP_OKAY, "read-only write");
		rd_chk(OFF_STACK1, 32'h434, "read-only kept");
		$display("test bus done");
		complete_run();
	end
endmodule
`default_nettype wire

// ==== tb/cie_fetch_model.sv ====
// bus master model standing in for the instruction fetch side of the execute core
`timescale 1ns/1ps
`default_nettype none
module cie_fetch_model
	import cie_pkg::*;
(
	input  wire logic              aclk,
	output logic      [ADDR_W-1:0] awaddr,
	output logic      [2:0]        awprot,
	output logic                   awvalid,
	input  wire logic              awready,
	output logic      [31:0]       wdata,
	output logic      [3:0]        wstrb,
	output logic                   wvalid,
	input  wire logic              wready,
	input  wire logic [1:0]        bresp,
	input  wire logic              bvalid,
	output logic                   bready,
	output logic      [ADDR_W-1:0] araddr,
	output logic      [2:0]        arprot,
	output logic                   arvalid,
	input  wire logic              arready,
	input  wire logic [31:0]       rdata,
	input  wire logic [1:0]        rresp,
	input  wire logic              rvalid,
	output logic                   rready
);
	initial
	begin
		{awaddr, awprot, awvalid, wdata, bready} = '0;
		{wvalid, araddr, arprot, arvalid, rready} = '0;
		wstrb = 4'hF;
	end

	// address and data go up together; each is released at the edge that takes it
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_left;
		logic w_left;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_left = 1'b1;
		w_left = 1'b1;
		do
		begin
			@(posedge aclk);
			if (aw_left && awready === 1'b1)
				awvalid <= 1'b0;
			if (w_left && wready === 1'b1)
				wvalid <= 1'b0;
			aw_left = aw_left && (awready !== 1'b1);
			w_left = w_left && (wready !== 1'b1);
		end
		while (aw_left || w_left);
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule
`default_nettype wire
